// >>> hdl/dcs_pkg.sv
// package: constants and types for the drive command source select block
package dcs_pkg;
  localparam logic [1:0]  SRC_TERMINAL      = 2'h0;
  localparam logic [1:0]  SRC_BUS           = 2'h1;
  localparam logic [1:0]  SRC_AND           = 2'h2;
  localparam logic [1:0]  SRC_OR            = 2'h3;
  localparam logic [1:0]  SETUP_MODE_RST    = 2'h3;
  localparam logic [1:0]  PRESET_MODE_RST   = 2'h3;
  localparam logic        PROFILE_ALT       = 1'h0;
  localparam logic        PROFILE_NATIVE    = 1'h1;
  localparam logic        PROFILE_RST       = 1'h1;
  localparam int          FREQ_W            = 16;
  // frequencies in tenths of a hertz
  localparam logic [15:0] JOG_FREQ_RST      = 16'h0064;
  localparam logic [15:0] FREQ_MIN          = 16'h0000;
  localparam logic [6:0]  TIMEOUT_SEC_MIN   = 7'h01;
  localparam logic [6:0]  TIMEOUT_SEC_MAX   = 7'h63;
  localparam logic [6:0]  TIMEOUT_SEC_RST   = 7'h01;
  localparam int          CLK_HZ            = 125000000;
  localparam int          SEC_CYCLES        = CLK_HZ;
  localparam logic [2:0]  REACT_OFF         = 3'h0;
  localparam logic [2:0]  REACT_RST         = 3'h0;
  localparam logic [3:0]  ADDR_SETUP_MODE   = 4'h0;
  localparam logic [3:0]  ADDR_PRESET_MODE  = 4'h1;
  localparam logic [3:0]  ADDR_JOG_ONE      = 4'h2;
  localparam logic [3:0]  ADDR_JOG_TWO      = 4'h3;
  localparam logic [3:0]  ADDR_PROFILE      = 4'h4;
  localparam logic [3:0]  ADDR_TIMEOUT      = 4'h5;
  localparam logic [3:0]  ADDR_REACTION     = 4'h6;
  localparam logic [3:0]  ADDR_FMAX         = 4'h7;
  localparam logic [3:0]  ADDR_STATUS       = 4'h8;
  localparam logic [15:0] FMAX_RST          = 16'h01f4;
  typedef enum logic [1:0] {
    LINK_OK   = 2'b01,
    LINK_LOST = 2'b10
  } link_state_t;
endpackage

// >>> hdl/code_merge.sv
// two-bit source merge: terminal, bus, and, or
`timescale 1ns/1ps
module code_merge
  import dcs_pkg::*;
(
  input  wire logic [1:0] mode,
  input  wire logic [1:0] term_code,
  input  wire logic [1:0] bus_code,
  output logic      [1:0] merged
);
  always_comb begin
    unique case (mode)
      SRC_TERMINAL: merged = term_code;
      SRC_BUS:      merged = bus_code;
      SRC_AND:      merged = term_code & bus_code;
      SRC_OR:       merged = term_code | bus_code;
    endcase
  end
endmodule

// >>> hdl/gap_timer.sv
// telegram gap timer: seconds prescaler plus seconds counter
`timescale 1ns/1ps
module gap_timer
  import dcs_pkg::*;
#(
  parameter int SEC_CYC = SEC_CYCLES
)(
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       restart,
  input  wire logic [6:0] limit_sec,
  output logic            expired
);
  typedef struct packed {
    logic [31:0] pre;
    logic [6:0]  sec;
    logic        exp;
  } gap_state_t;
  gap_state_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    if (restart) begin
      s_d.pre = 32'h0;
      s_d.sec = 7'h0;
      s_d.exp = 1'b0;
    end else if (!s_q.exp) begin
      if (s_q.pre == 32'(SEC_CYC - 1)) begin
        s_d.pre = 32'h0;
        s_d.sec = s_q.sec + 7'h1;
        // gap longer than the limit: one more full second elapsed
        if (s_q.sec >= limit_sec) s_d.exp = 1'b1;
      end else begin
        s_d.pre = s_q.pre + 32'h1;
      end
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign expired = s_q.exp;
endmodule

// >>> hdl/drive_command_source_select.sv
// top: parameter set, preset source, jog and bus timeout supervision
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module drive_command_source_select
  import dcs_pkg::*;
#(
  parameter int SEC_CYC = SEC_CYCLES
)(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic [1:0]  term_setup_code,
  input  wire logic [1:0]  term_preset_code,
  input  wire logic        telegram_valid,
  input  wire logic [1:0]  bus_setup_code,
  input  wire logic [1:0]  bus_preset_code,
  input  wire logic        bus_jog_one_req,
  input  wire logic        bus_jog_two_req,
  output logic      [2:0]  active_setup,
  output logic      [1:0]  preset_code,
  output logic             jog_active,
  output logic      [15:0] jog_freq,
  output logic             bus_lost,
  output logic      [2:0]  timeout_reaction,
  output logic             relay_on
);
  typedef struct packed {
    logic [1:0]  setup_mode;
    logic [1:0]  preset_mode;
    logic [15:0] jog_one;
    logic [15:0] jog_two;
    logic        profile;
    logic [6:0]  timeout_sec;
    logic [2:0]  reaction;
    logic [15:0] fmax;
    logic [15:0] rdata;
    logic [2:0]  setup;
    logic [1:0]  preset;
    logic        jog;
    logic [15:0] jfreq;
    link_state_t link;
    logic        relay;
  } top_state_t;

  top_state_t s_q, s_d;
  logic [1:0] setup_merged;
  logic [1:0] preset_merged;
  logic [1:0] bus_preset_eff;
  logic       gap_expired;

  // bus preset bits held at zero when the other profile is in force
  assign bus_preset_eff = (s_q.profile == PROFILE_NATIVE) ?
                          bus_preset_code : 2'h0;

  code_merge u_setup_merge (
    .mode      (s_q.setup_mode),
    .term_code (term_setup_code),
    .bus_code  (bus_setup_code),
    .merged    (setup_merged)
  );

  code_merge u_preset_merge (
    .mode      (s_q.preset_mode),
    .term_code (term_preset_code),
    .bus_code  (bus_preset_eff),
    .merged    (preset_merged)
  );

  gap_timer #(
    .SEC_CYC (SEC_CYC)
  ) u_gap_timer (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .restart   (telegram_valid),
    .limit_sec (s_q.timeout_sec),
    .expired   (gap_expired)
  );

  function automatic logic [15:0] clamp_freq(input logic [15:0] v,
                                             input logic [15:0] lim);
    clamp_freq = (v > lim) ? lim : v;
  endfunction

  always_comb begin
    s_d = s_q;
    // register writes
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_SETUP_MODE:  s_d.setup_mode  = reg_wdata[1:0];
        ADDR_PRESET_MODE: s_d.preset_mode = reg_wdata[1:0];
        ADDR_JOG_ONE:     s_d.jog_one = clamp_freq(reg_wdata, s_q.fmax);
        ADDR_JOG_TWO:     s_d.jog_two = clamp_freq(reg_wdata, s_q.fmax);
        ADDR_PROFILE:     s_d.profile     = reg_wdata[0];
        ADDR_TIMEOUT: begin
          // out-of-range limits are clamped into 1..99
          if (reg_wdata[15:0] < 16'(TIMEOUT_SEC_MIN))
            s_d.timeout_sec = TIMEOUT_SEC_MIN;
          else if (reg_wdata[15:0] > 16'(TIMEOUT_SEC_MAX))
            s_d.timeout_sec = TIMEOUT_SEC_MAX;
          else
            s_d.timeout_sec = reg_wdata[6:0];
        end
        ADDR_REACTION:    s_d.reaction    = reg_wdata[2:0];
        ADDR_FMAX: begin
          s_d.fmax    = reg_wdata;
          // jog speeds never exceed a lowered max frequency
          s_d.jog_one = clamp_freq(s_q.jog_one, reg_wdata);
          s_d.jog_two = clamp_freq(s_q.jog_two, reg_wdata);
        end
        default: ;
      endcase
    end
    // register reads, data valid in the following cycle
    s_d.rdata = 16'h0;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_SETUP_MODE:  s_d.rdata = {14'h0, s_q.setup_mode};
        ADDR_PRESET_MODE: s_d.rdata = {14'h0, s_q.preset_mode};
        ADDR_JOG_ONE:     s_d.rdata = s_q.jog_one;
        ADDR_JOG_TWO:     s_d.rdata = s_q.jog_two;
        ADDR_PROFILE:     s_d.rdata = {15'h0, s_q.profile};
        ADDR_TIMEOUT:     s_d.rdata = {9'h0, s_q.timeout_sec};
        ADDR_REACTION:    s_d.rdata = {13'h0, s_q.reaction};
        ADDR_FMAX:        s_d.rdata = s_q.fmax;
        ADDR_STATUS:      s_d.rdata = {8'h0, s_q.relay, s_q.jog,
                                       (s_q.link == LINK_LOST),
                                       2'h0, s_q.setup};
        default:          s_d.rdata = 16'h0;
      endcase
    end
    // active set is the merged code plus one
    s_d.setup  = {1'b0, setup_merged} + 3'h1;
    s_d.preset = preset_merged;
    // jog by bus only in the alternate profile, jog one takes priority
    s_d.jog   = 1'b0;
    s_d.jfreq = 16'h0;
    if (s_q.profile == PROFILE_ALT) begin
      if (bus_jog_one_req) begin
        s_d.jog   = 1'b1;
        s_d.jfreq = s_q.jog_one;
      end else if (bus_jog_two_req) begin
        s_d.jog   = 1'b1;
        s_d.jfreq = s_q.jog_two;
      end
    end
    // link supervision
    unique case (s_q.link)
      LINK_OK:   if (gap_expired) s_d.link = LINK_LOST;
      LINK_LOST: if (telegram_valid) s_d.link = LINK_OK;
      default:   s_d.link = LINK_OK;
    endcase
    // next-state link and reaction, so the relay moves in the same cycle
    s_d.relay = !((s_d.link == LINK_LOST) &&
                  (s_d.reaction != REACT_OFF));
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_q.setup_mode  <= SETUP_MODE_RST;
      s_q.preset_mode <= PRESET_MODE_RST;
      s_q.jog_one     <= JOG_FREQ_RST;
      s_q.jog_two     <= JOG_FREQ_RST;
      s_q.profile     <= PROFILE_RST;
      s_q.timeout_sec <= TIMEOUT_SEC_RST;
      s_q.reaction    <= REACT_RST;
      s_q.fmax        <= FMAX_RST;
      s_q.rdata       <= 16'h0;
      s_q.setup       <= 3'h1;
      s_q.preset      <= 2'h0;
      s_q.jog         <= 1'b0;
      s_q.jfreq       <= 16'h0;
      s_q.link        <= LINK_OK;
      s_q.relay       <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata        = s_q.rdata;
  assign active_setup     = s_q.setup;
  assign preset_code      = s_q.preset;
  assign jog_active       = s_q.jog;
  assign jog_freq         = s_q.jfreq;
  // one-hot lost bit taken straight from the state register
  assign bus_lost         = s_q.link[1];
  assign timeout_reaction = s_q.reaction;
  assign relay_on         = s_q.relay;
endmodule

// >>> tb/dcs_sva.sv
// assertion checker for the drive command source select top
`timescale 1ns/1ps
module dcs_sva
  import dcs_pkg::*;
#(
  parameter int SEC_CYC = SEC_CYCLES
)(
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic       reg_wr,
  input wire logic [1:0] term_setup_code,
  input wire logic       telegram_valid,
  input wire logic [1:0] bus_setup_code,
  input wire logic       bus_jog_one_req,
  input wire logic       bus_jog_two_req,
  input wire logic [2:0] active_setup,
  input wire logic       jog_active,
  input wire logic       bus_lost,
  input wire logic [2:0] timeout_reaction,
  input wire logic       relay_on
);
  int quiet_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // cycles since the last telegram, saturating
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) quiet_q <= 0;
    else if (telegram_valid) quiet_q <= 0;
    else if (quiet_q < 100000) quiet_q <= quiet_q + 1;
  end
  sequence quiet_s;
    !reg_wr && $stable(term_setup_code) && $stable(bus_setup_code);
  endsequence
  chk_setup_range: assert property (
      active_setup inside {[1:4]})
    else $error("active set out of range");
  chk_setup_stable: assert property (
      quiet_s[*3] |=> $stable(active_setup))
    else $error("active set moved with steady inputs");
  chk_jog_idle: assert property (
      !bus_jog_one_req && !bus_jog_two_req |=> !jog_active)
    else $error("jog without request");
  chk_lost_wait: assert property (
      $rose(bus_lost) |-> quiet_q >= 2*SEC_CYC-2)
    else $error("link lost too early");
  chk_lost_hold: assert property (
      (!telegram_valid)[*3] ##0 bus_lost |=> bus_lost)
    else $error("link lost cleared without telegram");
  chk_lost_clear: assert property (
      telegram_valid |-> ##3 (!bus_lost)[*8])
    else $error("telegram did not restart timer");
  chk_relay_drop: assert property (
      bus_lost && timeout_reaction != 3'h0 |-> !relay_on)
    else $error("relay kept on after timeout");
  chk_relay_ok: assert property (
      !bus_lost |-> relay_on)
    else $error("relay off with link up");
  cover property ($rose(bus_lost));
  cover property (jog_active);
  cover property (telegram_valid ##1 !telegram_valid);
endmodule
bind drive_command_source_select dcs_sva #(.SEC_CYC(SEC_CYC)) u_sva (
  .clk_sys(clk_sys), .rst_b(rst_b), .reg_wr(reg_wr),
  .term_setup_code(term_setup_code), .telegram_valid(telegram_valid),
  .bus_setup_code(bus_setup_code), .bus_jog_one_req(bus_jog_one_req),
  .bus_jog_two_req(bus_jog_two_req), .active_setup(active_setup),
  .jog_active(jog_active), .bus_lost(bus_lost),
  .timeout_reaction(timeout_reaction), .relay_on(relay_on));

// >>> tb/bus_master_model.sv
// serial bus master model: periodic telegrams carrying codes and jogs
`timescale 1ns/1ps
module bus_master_model (
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic [7:0] gap,
  input  wire logic [1:0] setup_in,
  input  wire logic [1:0] preset_in,
  input  wire logic [1:0] jog_in,
  output logic            telegram_valid,
  output logic      [1:0] bus_setup_code,
  output logic      [1:0] bus_preset_code,
  output logic            bus_jog_one_req,
  output logic            bus_jog_two_req
);
  logic [7:0] cnt_q;
  // gap zero silences the bus; codes change only with a telegram
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 8'h00;
      telegram_valid <= 1'b0;
      bus_setup_code  <= 2'h0;
      bus_preset_code <= 2'h0;
      bus_jog_one_req <= 1'b0;
      bus_jog_two_req <= 1'b0;
    end else begin
      telegram_valid <= 1'b0;
      cnt_q <= cnt_q + 8'h01;
      if (gap != 8'h00 && cnt_q >= gap) begin
        cnt_q <= 8'h00;
        telegram_valid <= 1'b1;
        {bus_setup_code, bus_preset_code} <= {setup_in, preset_in};
        {bus_jog_one_req, bus_jog_two_req} <= jog_in;
      end
    end
  end
endmodule

// >>> tb/drive_command_source_select_tb.sv
// self-checking bench for the drive command source select block
`timescale 1ns/1ps
module drive_command_source_select_tb
  import dcs_pkg::*;
;
  logic        clk_sys, rst_b, reg_wr, reg_rd, tel, j1, j2;
  logic        jog_active, bus_lost, relay_on;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, jog_freq;
  logic [1:0]  tsc, tpc, bsc, bpc, su, pu, ju, preset_code;
  logic [2:0]  active_setup, timeout_reaction;
  logic [7:0]  gap;
  int          n_mismatch, comparisons, m, pm, pr, t, b, tp, bp, jf, e;
  logic [15:0] rv [10] = '{16'h3, 16'h3, 16'h64, 16'h64, 16'h1, 16'h1,
                           16'h0, 16'h1f4, 16'h81, 16'h0};
  drive_command_source_select #(.SEC_CYC(10)) dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .term_setup_code(tsc), .term_preset_code(tpc),
    .telegram_valid(tel), .bus_setup_code(bsc), .bus_preset_code(bpc),
    .bus_jog_one_req(j1), .bus_jog_two_req(j2),
    .active_setup(active_setup), .preset_code(preset_code),
    .jog_active(jog_active), .jog_freq(jog_freq), .bus_lost(bus_lost),
    .timeout_reaction(timeout_reaction), .relay_on(relay_on));
  bus_master_model partner (
    .clk_sys(clk_sys), .rst_b(rst_b), .gap(gap), .setup_in(su),
    .preset_in(pu), .jog_in(ju), .telegram_valid(tel),
    .bus_setup_code(bsc), .bus_preset_code(bpc),
    .bus_jog_one_req(j1), .bus_jog_two_req(j2));
  function automatic int mrg(int md, int x, int y);
    case (md)
      0: return x;
      1: return y;
      2: return x & y;
      default: return x | y;
    endcase
  endfunction
  task automatic close_out;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input int exp);
    comparisons++;
    if (got !== 16'(exp)) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // strobe stays up between back-to-back writes, dropped by the next task
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, d, 2'b10};
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [3:0] a, input int exp);
    {reg_addr, reg_wr, reg_rd} <= {a, 2'b01};
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    // read data stand only in the cycle after the strobe
    #1 chk(reg_rdata, exp);
  endtask
  task automatic cyc(input int n);
    reg_wr <= 1'b0;
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_tel;
    reg_wr <= 1'b0;
    for (int k = 0; k < 300 && tel !== 1'b1; k++) cyc(1);
    if (tel !== 1'b1) begin
      n_mismatch++;
      $display("unexpected at %0t: no telegram seen", $time);
      close_out();
    end
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {tsc, tpc, su, pu, ju} = '0;
    gap = 8'h03;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    void'($urandom(60));
    // reset values of every register, then an unmapped address
    for (int i = 0; i < 10; i++) begin
      rd(4'(i), rv[i]);
    end
    wr(ADDR_JOG_TWO, 16'h0258);
    rd(ADDR_JOG_TWO, 500);
    for (int i = 0; i < 16; i++) begin
      m = i % 4;
      pm = i / 4;
      pr = $urandom % 2;
      t = $urandom % 4;
      b = $urandom % 4;
      tp = $urandom % 4;
      bp = $urandom % 4;
      jf = $urandom % 501;
      wr(ADDR_SETUP_MODE, 16'(m));
      wr(ADDR_PRESET_MODE, 16'(pm));
      wr(ADDR_PROFILE, 16'(pr));
      wr(ADDR_JOG_ONE, 16'(jf));
      tsc <= 2'(t);
      su  <= 2'(b);
      tpc <= 2'(tp);
      pu  <= 2'(bp);
      ju  <= 2'($urandom % 4);
      cyc(12);
      e = mrg(m, t, b) + 1;
      chk(active_setup, e);
      chk(preset_code, mrg(pm, tp, pr == 1 ? bp : 0));
      chk(jog_active, pr == 0 && ju != 2'b00);
      // jog two was clamped to the max frequency; no jog gives zero
      e = (pr == 0 && ju != 2'b00) ? (ju[1] ? jf : 500) : 0;
      chk(jog_freq, e);
    end
    wr(ADDR_TIMEOUT, 16'h0000);
    rd(ADDR_TIMEOUT, 1);
    wr(ADDR_TIMEOUT, 16'h00c8);
    rd(ADDR_TIMEOUT, 99);
    wr(ADDR_TIMEOUT, 16'h0002);
    wr(ADDR_REACTION, 16'h0003);
    wait_tel();
    gap <= 8'h00;
    cyc(25);
    chk(bus_lost, 0);
    cyc(15);
    chk(bus_lost, 1);
    chk(relay_on, 0);
    chk(timeout_reaction, 3);
    wr(ADDR_REACTION, 16'h0000);
    cyc(3);
    chk(relay_on, 1);
    gap <= 8'h03;
    cyc(12);
    chk(bus_lost, 0);
    close_out();
  end
endmodule
